//--- rtl/aelc_pkg.sv
// shared constants and types for the exposure lock control block
package aelc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_LOCK_CTRL   = 8'hAC;
  localparam logic [7:0] IDX_LUMA_TARGET = 8'hAD;
  localparam logic [7:0] IDX_INV_THRESH  = 8'hAE;
  localparam logic [7:0] IDX_MAXEXP_UP   = 8'hB0;
  localparam logic [7:0] IDX_MAXEXP_MID  = 8'hB1;
  localparam logic [7:0] IDX_MAXEXP_LOW  = 8'hB2;
  localparam logic [7:0] IDX_RED_TARGET  = 8'hB3;
  localparam logic [7:0] IDX_BLUE_TARGET = 8'hB4;
  localparam logic [7:0] IDX_FSTEP_UP    = 8'hB5;
  localparam logic [7:0] IDX_FSTEP_MID   = 8'hB6;
  localparam logic [7:0] IDX_FSTEP_LOW   = 8'hB7;
  localparam logic [7:0] IDX_LOCK_STATUS = 8'hB8;
  localparam logic [7:0] IDX_MODE_CTRL   = 8'hB9;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'hBA;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'hBB;

  // lock control fields
  localparam int LOCK_EN_BIT   = 7;
  localparam int LOCK_TH_MSB   = 6;
  localparam int LOCK_TH_LSB   = 4;
  localparam int UNLOCK_TH_MSB = 3;
  localparam int UNLOCK_TH_LSB = 0;

  // mode control fields
  localparam int MODE_PIXEL_BIT   = 0;
  localparam int MODE_FLICKER_BIT = 1;
  localparam int MODE_REFCORR_BIT = 2;

  // lock status fields
  localparam int STAT_AE_BIT      = 0;
  localparam int STAT_AWB_BIT     = 1;
  localparam int STAT_STRETCH_BIT = 2;

  // interrupt event fields
  localparam int IRQ_AE_CHG_BIT  = 0;
  localparam int IRQ_AWB_CHG_BIT = 1;
  localparam int IRQ_REJECT_BIT  = 2;
  localparam int IRQ_W           = 3;

  // reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_MAXEXP_UP  = 8'h14;
  localparam logic [7:0] RST_MAXEXP_MID = 8'h58;
  localparam logic [7:0] RST_MAXEXP_LOW = 8'h55;
  localparam logic [7:0] RST_FSTEP_MID  = 8'hB2;
  localparam logic [7:0] RST_FSTEP_LOW  = 8'h07;
  localparam logic [7:0] RST_GAIN       = 8'h80;
  localparam logic [23:0] RST_INTEG     = 24'h00_0100;

  // per-frame statistics delivered by the measurement path
  typedef struct packed {
    logic [7:0] y_mean;
    logic [7:0] cr_mean;
    logic [7:0] cb_mean;
    logic [7:0] invalid_count;
    logic       stretch_active;
  } aelc_frame_s;
endpackage : aelc_pkg

//--- rtl/aelc_top.sv
// exposure and white-balance lock control with apb register file
`timescale 1ns/100ps

// How it works
// - each frame, difference of luminance target and measured mean drives lock decisions
// - while unlocked, integration time keeps stepping toward the target
// - difference under lock threshold means locked; adjustments stop
// - while locked, difference above unlock threshold leaves lock, adjustment resumes
// - exposure lock only acts in pixel mode; white-balance lock uses the lock settings in every mode
// - lock function bit 7 zero: unlock threshold used for both decisions
// - lock function bit one: separate lock and unlock thresholds
// - lock threshold bits 6..4, unlock threshold bits 3..0
// - luminance target is a full software-writable byte
// - invalid pixel limit applies only with reference correction enabled
// - integration time clamped to the 24-bit maximum exposure except in flicker mode
// - white balance tracks red and blue difference targets
// - flicker mode: integration time written only as multiples of the step
// - pixel mode: the flicker step is the lower bound for downward steps
// - read-only status: stretch bit 2, white balance bit 1, exposure bit 0
module aelc_top
  import aelc_pkg::*;
#(
  parameter logic [23:0] FREE_STEP = 24'h00_0010,
  parameter int          ADDR_W    = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              frame_done,
  input  wire aelc_frame_s       frame_stats,
  output logic [23:0]            integ_time,
  output logic                   integ_wr,
  output logic [7:0]             red_gain,
  output logic [7:0]             blue_gain,
  output logic                   irq
);

  // register storage
  logic [7:0]       lock_ctrl_r;
  logic [7:0]       luma_target_r;
  logic [7:0]       inv_thresh_r;
  logic [23:0]      max_exp_r;
  logic [7:0]       red_target_r;
  logic [7:0]       blue_target_r;
  logic [23:0]      fstep_r;
  logic [2:0]       mode_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [2:0]       lock_stat_r;

  // bus signals
  logic             pready_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;
  logic             acc;
  logic             wr_en;
  logic [7:0]       idx;
  logic             idx_ok;
  logic             hit;
  logic [31:0]      rd_mux;

  // exposure path
  logic [23:0]      integ_r;
  logic [23:0]      integ_nxt;
  logic             integ_wr_r;
  logic             ae_lock_r;
  logic             ae_lock_nxt;
  logic             af_aligned_r;
  logic [7:0]       abs_diff;
  logic             too_dark;
  logic [3:0]       lock_th;
  logic [3:0]       unlock_th;
  logic             frame_ok;
  logic             adjust;
  logic [24:0]      step_sum;
  logic [23:0]      step;
  logic [23:0]      floor_v;
  logic [24:0]      floor_sum;

  // white-balance path; channel 0 red difference, channel 1 blue difference
  logic [7:0]       chr_target [2];
  logic [7:0]       chr_mean   [2];
  logic [7:0]       chr_diff   [2];
  logic [7:0]       chr_gain_r [2];
  logic             chr_near   [2];
  logic             chr_far    [2];
  logic             awb_lock_r;
  logic             awb_lock_nxt;
  logic [IRQ_W-1:0] irq_evt;
  logic             irq_r;

  // apb decode; word aligned, index is byte address over four
  assign acc    = psel & penable & pready_r;
  assign wr_en  = acc & pwrite;
  assign idx_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
  assign idx    = paddr[9:2];

  // read mux and address hit
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = idx_ok;
    unique case (idx)
      IDX_LOCK_CTRL:   rd_mux[7:0] = lock_ctrl_r;
      IDX_LUMA_TARGET: rd_mux[7:0] = luma_target_r;
      IDX_INV_THRESH:  rd_mux[7:0] = inv_thresh_r;
      IDX_MAXEXP_UP:   rd_mux[7:0] = max_exp_r[23:16];
      IDX_MAXEXP_MID:  rd_mux[7:0] = max_exp_r[15:8];
      IDX_MAXEXP_LOW:  rd_mux[7:0] = max_exp_r[7:0];
      IDX_RED_TARGET:  rd_mux[7:0] = red_target_r;
      IDX_BLUE_TARGET: rd_mux[7:0] = blue_target_r;
      IDX_FSTEP_UP:    rd_mux[7:0] = fstep_r[23:16];
      IDX_FSTEP_MID:   rd_mux[7:0] = fstep_r[15:8];
      IDX_FSTEP_LOW:   rd_mux[7:0] = fstep_r[7:0];
      IDX_LOCK_STATUS: rd_mux[2:0] = lock_stat_r;
      IDX_MODE_CTRL:   rd_mux[2:0] = mode_r;
      IDX_IRQ_STATUS:  rd_mux[IRQ_W-1:0] = irq_stat_r;
      IDX_IRQ_MASK:    rd_mux[IRQ_W-1:0] = irq_mask_r;
      default:         hit = 1'b0;
    endcase
    if (!hit) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // no wait states: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel & ~penable;
      prdata_r  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_r <= psel & ~penable & ~hit;
    end
  end

  // software-writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_ctrl_r   <= RST_ZERO;
      luma_target_r <= RST_ZERO;
      inv_thresh_r  <= RST_ZERO;
      max_exp_r     <= {RST_MAXEXP_UP, RST_MAXEXP_MID, RST_MAXEXP_LOW};
      red_target_r  <= RST_ZERO;
      blue_target_r <= RST_ZERO;
      fstep_r       <= {RST_ZERO, RST_FSTEP_MID, RST_FSTEP_LOW};
      mode_r        <= 3'b000;
      irq_mask_r    <= '0;
    end else if (wr_en && hit) begin
      unique case (idx)
        IDX_LOCK_CTRL:   lock_ctrl_r   <= pwdata[7:0];
        IDX_LUMA_TARGET: luma_target_r <= pwdata[7:0];
        IDX_INV_THRESH:  inv_thresh_r  <= pwdata[7:0];
        IDX_MAXEXP_UP:   max_exp_r[23:16] <= pwdata[7:0];
        IDX_MAXEXP_MID:  max_exp_r[15:8]  <= pwdata[7:0];
        IDX_MAXEXP_LOW:  max_exp_r[7:0]   <= pwdata[7:0];
        IDX_RED_TARGET:  red_target_r  <= pwdata[7:0];
        IDX_BLUE_TARGET: blue_target_r <= pwdata[7:0];
        IDX_FSTEP_UP:    fstep_r[23:16] <= pwdata[7:0];
        IDX_FSTEP_MID:   fstep_r[15:8]  <= pwdata[7:0];
        IDX_FSTEP_LOW:   fstep_r[7:0]   <= pwdata[7:0];
        IDX_MODE_CTRL:   mode_r        <= pwdata[2:0];
        IDX_IRQ_MASK:    irq_mask_r    <= pwdata[IRQ_W-1:0];
        default:         mode_r        <= mode_r;
      endcase
    end
  end

  // luminance difference and effective thresholds
  always_comb begin
    too_dark = luma_target_r > frame_stats.y_mean;
    abs_diff = too_dark ? (luma_target_r - frame_stats.y_mean)
                        : (frame_stats.y_mean - luma_target_r);
    unlock_th = lock_ctrl_r[UNLOCK_TH_MSB:UNLOCK_TH_LSB];
    if (lock_ctrl_r[LOCK_EN_BIT]) begin
      lock_th = {1'b0, lock_ctrl_r[LOCK_TH_MSB:LOCK_TH_LSB]};
    end else begin
      lock_th = unlock_th;
    end
  end

  // frame rejected when too many invalid pixels and correction is on
  assign frame_ok = !(mode_r[MODE_REFCORR_BIT] &&
                      (frame_stats.invalid_count > inv_thresh_r));

  // lock decision with hysteresis, only in pixel mode
  always_comb begin
    ae_lock_nxt = ae_lock_r;
    if (!mode_r[MODE_PIXEL_BIT]) begin
      ae_lock_nxt = 1'b0;
    end else if (!ae_lock_r) begin
      ae_lock_nxt = abs_diff < {4'h0, lock_th};
    end else begin
      ae_lock_nxt = !(abs_diff > {4'h0, unlock_th});
    end
  end

  // step size, lower bound and next integration time
  always_comb begin
    step      = mode_r[MODE_FLICKER_BIT] ? fstep_r : FREE_STEP;
    floor_v   = mode_r[MODE_PIXEL_BIT] ? fstep_r : step;
    adjust    = frame_ok && !ae_lock_nxt && (abs_diff != 8'h00);
    floor_sum = {1'b0, floor_v} + {1'b0, step}; // no wrap near the top of the range
    step_sum  = 25'h000_0000;
    integ_nxt = integ_r;
    if (mode_r[MODE_FLICKER_BIT] && !af_aligned_r) begin
      integ_nxt = fstep_r; // realign onto the step grid
    end else if (adjust && too_dark) begin
      step_sum = {1'b0, integ_r} + {1'b0, step};
      if (step_sum <= {1'b0, max_exp_r}) begin
        integ_nxt = step_sum[23:0];
      end else if (!mode_r[MODE_FLICKER_BIT]) begin
        integ_nxt = max_exp_r;
      end
    end else if (adjust) begin
      if ({1'b0, integ_r} >= floor_sum) begin
        integ_nxt = integ_r - step;
      end else if (!mode_r[MODE_FLICKER_BIT]) begin
        integ_nxt = floor_v;
      end
    end
    if (integ_nxt > max_exp_r && !mode_r[MODE_FLICKER_BIT]) begin
      integ_nxt = max_exp_r;
    end
  end

  // exposure state, once per completed frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_r      <= RST_INTEG;
      integ_wr_r   <= 1'b0;
      ae_lock_r    <= 1'b0;
      af_aligned_r <= 1'b0;
    end else begin
      integ_wr_r <= 1'b0;
      if (!mode_r[MODE_FLICKER_BIT]) begin
        af_aligned_r <= 1'b0;
      end
      if (frame_done) begin
        if (frame_ok) begin
          ae_lock_r <= ae_lock_nxt;
        end
        if (mode_r[MODE_FLICKER_BIT]) begin
          af_aligned_r <= 1'b1;
        end
        if (integ_nxt != integ_r) begin
          integ_r    <= integ_nxt;
          integ_wr_r <= 1'b1;
        end
      end
    end
  end

  // channel inputs for the chroma loop
  assign chr_target[0] = red_target_r;
  assign chr_target[1] = blue_target_r;
  assign chr_mean[0]   = frame_stats.cr_mean;
  assign chr_mean[1]   = frame_stats.cb_mean;

  // per channel: distance to target, threshold tests, one-count gain step
  for (genvar ch = 0; ch < 2; ch++) begin : g_chroma
    always_comb begin
      chr_diff[ch] = (chr_target[ch] > chr_mean[ch]) ? (chr_target[ch] - chr_mean[ch])
                                                     : (chr_mean[ch] - chr_target[ch]);
      chr_near[ch] = chr_diff[ch] < {4'h0, lock_th};
      chr_far[ch]  = chr_diff[ch] > {4'h0, unlock_th};
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chr_gain_r[ch] <= RST_GAIN;
      end else if (frame_done && frame_ok && !awb_lock_nxt) begin
        if (chr_mean[ch] < chr_target[ch] && chr_gain_r[ch] != 8'hFF) begin
          chr_gain_r[ch] <= chr_gain_r[ch] + 8'h01;
        end else if (chr_mean[ch] > chr_target[ch] && chr_gain_r[ch] != 8'h00) begin
          chr_gain_r[ch] <= chr_gain_r[ch] - 8'h01;
        end
      end
    end
  end

  // white-balance lock with the same effective thresholds
  always_comb begin
    if (!awb_lock_r) begin
      awb_lock_nxt = chr_near[0] && chr_near[1];
    end else begin
      awb_lock_nxt = !(chr_far[0] || chr_far[1]);
    end
  end

  // white-balance lock state, once per accepted frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      awb_lock_r <= 1'b0;
    end else if (frame_done && frame_ok) begin
      awb_lock_r <= awb_lock_nxt;
    end
  end

  // status flags latch at frame end only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_stat_r <= 3'b000;
    end else if (frame_done) begin
      lock_stat_r[STAT_AE_BIT]      <= frame_ok ? ae_lock_nxt : ae_lock_r;
      lock_stat_r[STAT_AWB_BIT]     <= frame_ok ? awb_lock_nxt : awb_lock_r;
      lock_stat_r[STAT_STRETCH_BIT] <= frame_stats.stretch_active;
    end
  end

  // interrupt events: lock changes and rejected frames
  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_AE_CHG_BIT]  = frame_done && frame_ok && (ae_lock_nxt != ae_lock_r);
    irq_evt[IRQ_AWB_CHG_BIT] = frame_done && frame_ok && (awb_lock_nxt != awb_lock_r);
    irq_evt[IRQ_REJECT_BIT]  = frame_done && !frame_ok;
  end

  // sticky status, write one to clear, new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else if (wr_en && hit && idx == IDX_IRQ_STATUS) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // outputs straight from flops
  assign pready     = pready_r;
  assign prdata     = prdata_r;
  assign pslverr    = pslverr_r;
  assign integ_time = integ_r;
  assign integ_wr   = integ_wr_r;
  assign red_gain   = chr_gain_r[0];
  assign blue_gain  = chr_gain_r[1];
  assign irq        = irq_r;

endmodule : aelc_top

//--- tb/aelc_properties.sv
// port assertions for the exposure lock control block
`timescale 1ns/100ps
module aelc_checker
  import aelc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              frame_done,
  input wire aelc_frame_s       frame_stats,
  input wire logic [23:0]       integ_time,
  input wire logic              integ_wr,
  input wire logic [7:0]        red_gain,
  input wire logic [7:0]        blue_gain,
  input wire logic              irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // bus phases
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  ready_in_access_a: assert property (apb_setup ##1 apb_access |-> pready)
    else $error("pready missing in access cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  read_byte_wide_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  integ_per_frame_a: assert property ($changed(integ_time) |-> integ_wr && $past(frame_done))
    else $error("integration time changed outside frame");
  integ_wr_cause_a: assert property (integ_wr |-> $past(frame_done))
    else $error("integration write without frame");
  gain_step_a: assert property ($changed(red_gain) |-> $past(frame_done) &&
    (8'(red_gain - $past(red_gain)) == 8'h01 || 8'($past(red_gain) - red_gain) == 8'h01))
    else $error("red gain moved wrongly");
  irq_rise_a: assert property ($rose(irq) |-> $past(frame_done, 2) ||
    $past(psel && penable && pwrite, 2))
    else $error("interrupt rose without cause");
  cover property (integ_wr);
endmodule : aelc_checker

bind aelc_top aelc_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .frame_done(frame_done),
  .frame_stats(frame_stats), .integ_time(integ_time), .integ_wr(integ_wr),
  .red_gain(red_gain), .blue_gain(blue_gain), .irq(irq));

//--- tb/aelc_sensor_model.sv
// image sensor integration time register model
`timescale 1ns/100ps
module aelc_sensor_model
  import aelc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [23:0] integ_time,
  input wire logic        integ_wr,
  output logic [23:0]     sensor_integ
);
  // latch each programmed integration time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_integ <= RST_INTEG;
    end else if (integ_wr) begin
      sensor_integ <= integ_time;
    end
  end
endmodule : aelc_sensor_model

//--- tb/test_aelc_top.sv
// self-checking bench for the exposure lock control block
`timescale 1ns/100ps
module test_aelc_top
  import aelc_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, frame_done = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  aelc_frame_s frame_stats = '0;
  logic        pready, pslverr, integ_wr, irq, err, lk, en;
  logic [23:0] integ_time, sensor_integ, i0;
  logic [7:0]  red_gain, blue_gain, tgt, w;
  int          num_errors = 0, n_checks = 0, cycles = 0, d, lth, uth;

  always #4 pclk = ~pclk;

  aelc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .frame_done(frame_done), .frame_stats(frame_stats),
    .integ_time(integ_time), .integ_wr(integ_wr), .red_gain(red_gain),
    .blue_gain(blue_gain), .irq(irq));
  aelc_sensor_model sensor (.pclk(pclk), .presetn(presetn), .integ_time(integ_time),
    .integ_wr(integ_wr), .sensor_integ(sensor_integ));

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // one apb transfer, held until pready is sampled high
  task automatic apb(logic wr, logic [7:0] idx, logic [31:0] wd);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb

  // one frame of statistics, then let results and irq settle
  task automatic frame(logic [7:0] y, cr, cb, inv, logic st);
    frame_done <= 1;
    frame_stats <= '{y, cr, cb, inv, st};
    @(posedge pclk);
    frame_done <= 0;
    repeat (2) @(posedge pclk);
  endtask : frame

  function automatic logic [31:0] rst_val(int i);
    case (i)
      'hB0: return 32'h0000_0014;
      'hB1: return 32'h0000_0058;
      'hB2: return 32'h0000_0055;
      'hB6: return 32'h0000_00B2;
      'hB7: return 32'h0000_0007;
      default: return 32'h0000_0000;
    endcase
  endfunction : rst_val

  // next lock state from the effective thresholds
  function automatic logic lock_next(logic was, int dd, logic e, int l, int u);
    return was ? !(dd > u) : (dd < (e ? l : u));
  endfunction : lock_next

  task automatic set24(logic [7:0] up, logic [23:0] v);
    apb(1, up, {24'h00_0000, v[23:16]});
    apb(1, up + 8'h01, {24'h00_0000, v[15:8]});
    apb(1, up + 8'h02, {24'h00_0000, v[7:0]});
  endtask : set24

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 30000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h602c263c));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    check("integ reset", integ_time, RST_INTEG);
    check("gain reset", {8'h00, red_gain, blue_gain, 7'h00, irq}, {8'h00, RST_GAIN, RST_GAIN, 8'h00});
    // reset values, with the unmapped hole among them
    for (int i = 'hAC; i <= 'hB8; i++) begin
      apb(0, 8'(i), 0);
      check("reset value", rd, rst_val(i));
      check("reset error", {31'h0000_0000, err}, {31'h0000_0000, 1'(i == 'hAF)});
    end
    // random write and readback of every writable byte except mode control, interrupt status and interrupt mask
    for (int i = 'hAC; i <= 'hB7; i++) begin
      w = 8'($urandom);
      apb(1, 8'(i), {24'h00_0000, w});
      apb(0, 8'(i), 0);
      if (i != 'hAF) check("readback", rd, {24'h00_0000, w});
    end
    apb(1, IDX_LOCK_STATUS, 32'h0000_00FF);
    apb(0, IDX_LOCK_STATUS, 0);
    check("status read only", rd, 32'h0000_0000);
    // random lock and unlock decisions in pixel mode
    for (int r = 0; r < 4; r++) begin
      en = 1'($urandom);
      lth = $urandom % 8;
      uth = $urandom % 16;
      tgt = 8'(64 + $urandom % 128);
      lk = 0;
      apb(1, IDX_MODE_CTRL, 32'h0000_0001);
      apb(1, IDX_LOCK_CTRL, {24'h00_0000, en, 3'(lth), 4'(uth)});
      apb(1, IDX_LUMA_TARGET, {24'h00_0000, tgt});
      apb(0, IDX_LOCK_STATUS, 0);
      lk = rd[0];
      for (int f = 0; f < 10; f++) begin
        case (f % 5)
          0: d = 0;
          1: d = lth;
          2: d = uth;
          3: d = uth + 1;
          default: d = $urandom % 20;
        endcase
        i0 = integ_time;
        w = 8'($urandom % 2);
        frame(f[0] ? tgt + 8'(d) : tgt - 8'(d), 8'h80, 8'h80, 8'h00, w[0]);
        apb(0, IDX_LOCK_STATUS, 0);
        if (lk && lock_next(lk, d, en, lth, uth)) check("held", integ_time, i0);
        lk = lock_next(lk, d, en, lth, uth);
        check("ae lock", rd[0], lk);
        check("stretch", rd[2], w[0]);
      end
      apb(1, IDX_MODE_CTRL, 32'h0000_0000);
      frame(tgt, 8'h80, 8'h80, 8'h00, 1'b0);
      apb(0, IDX_LOCK_STATUS, 0);
      check("no lock outside pixel", rd[0], 1'b0);
    end
    // clamp to maximum and floor, free stepping
    set24(IDX_MAXEXP_UP, 24'h00_0130);
    set24(IDX_FSTEP_UP, 24'h00_00C0);
    apb(1, IDX_LOCK_CTRL, 32'h0000_0000);
    apb(1, IDX_LUMA_TARGET, 32'h0000_0080);
    apb(1, IDX_MODE_CTRL, 32'h0000_0001);
    repeat (24) frame(8'h00, 8'h80, 8'h80, 8'h00, 1'b0);
    check("max clamp", integ_time, 24'h00_0130);
    repeat (10) frame(8'hFF, 8'h80, 8'h80, 8'h00, 1'b0);
    check("floor clamp", integ_time, 24'h00_00C0);
    // flicker stepping in multiples of the unit time
    set24(IDX_MAXEXP_UP, 24'h00_0140);
    set24(IDX_FSTEP_UP, 24'h00_0040);
    apb(1, IDX_MODE_CTRL, 32'h0000_0003);
    for (int f = 0; f < 16; f++) begin
      frame(f < 8 ? 8'h00 : 8'hFF, 8'h80, 8'h80, 8'h00, 1'b0);
      check("flicker multiple", sensor_integ % 24'h00_0040, 0);
      if (f == 7) check("flicker max", sensor_integ, 24'h00_0140);
    end
    check("flicker floor", sensor_integ, 24'h00_0040);
    // white balance gains move toward the chroma targets
    apb(1, IDX_RED_TARGET, 32'h0000_00A0);
    apb(1, IDX_BLUE_TARGET, 32'h0000_0060);
    w = red_gain;
    tgt = blue_gain;
    frame(8'h80, 8'h10, 8'hF0, 8'h00, 1'b0);
    check("red gain", red_gain, w + 8'h01);
    check("blue gain", blue_gain, tgt - 8'h01);
    // rejected frame, interrupt raise, clear and mask
    apb(1, IDX_IRQ_MASK, 32'h0000_0004);
    apb(1, IDX_INV_THRESH, 32'h0000_0005);
    apb(1, IDX_MODE_CTRL, 32'h0000_0005);
    i0 = integ_time;
    frame(8'h00, 8'h80, 8'h80, 8'h06, 1'b0);
    check("reject keeps integ", integ_time, i0);
    check("irq raised", irq, 1'b1);
    apb(1, IDX_IRQ_STATUS, 32'h0000_0004);
    @(posedge pclk);
    check("irq cleared", irq, 1'b0);
    apb(1, IDX_IRQ_MASK, 32'h0000_0000);
    frame(8'h00, 8'h80, 8'h80, 8'h06, 1'b0);
    apb(0, IDX_IRQ_STATUS, 0);
    check("masked irq", {irq, rd[2]}, 2'b01);
    apb(1, IDX_IRQ_STATUS, 32'h0000_0007);
    apb(1, IDX_MODE_CTRL, 32'h0000_0001);
    frame(8'h00, 8'h80, 8'h80, 8'hC8, 1'b0);
    apb(0, IDX_IRQ_STATUS, 0);
    check("limit ignored", rd[2], 1'b0);
    give_verdict();
  end
endmodule : test_aelc_top
